/* include/tw_pkg.sv */
package tw_pkg;
  // Startup overhead, in clock periods.
  localparam logic [3:0] BASE_START_CYC = 4'h1;
  localparam logic [3:0] ROOT_LIMIT_CYC = 4'h2;
  localparam logic [3:0] NO_EARLY_CYC = 4'h6;
  // Descriptor word layout.
  localparam int DT_LSB = 0;
  localparam int WP_BIT = 2;
  localparam int USED_BIT = 3;
  localparam int MOD_BIT = 4;
  localparam logic [31:0] TBL_ADDR_MASK = 32'hFFFFFFF0;
  localparam logic [1:0] DT_INVALID = 2'h0;
  localparam logic [1:0] DT_PAGE = 2'h1;
  localparam logic [1:0] DT_SHORT = 2'h2;
  localparam logic [1:0] DT_LONG = 2'h3;
  // Index scale as a shift: four or eight bytes per descriptor.
  localparam logic [1:0] SHORT_SHIFT = 2'h2;
  localparam logic [1:0] LONG_SHIFT = 2'h3;
  // Walk sequencer states.
  typedef enum logic [5:0] {
    W_IDLE = 6'h01,
    W_START = 6'h02,
    W_FETCH = 6'h04,
    W_CHECK = 6'h08,
    W_UPDATE = 6'h10,
    W_PARK = 6'h20
  } walk_e;
  // Logical bus yield states.
  typedef enum logic [4:0] {
    Y_IDLE = 5'h01,
    Y_OWN = 5'h02,
    Y_PEND = 5'h04,
    Y_TRI = 5'h08,
    Y_OFF = 5'h10
  } yield_e;
endpackage

/* include/yield_if.sv */
`timescale 1ns/100ps
interface yield_if;
  logic walk_req;
  logic cycle_busy;
  logic grant_in;
  logic grant_out;
  logic ctrl_oe;
  logic ack;
  modport ctrl (input walk_req, input cycle_busy, input grant_in,
                output grant_out, output ctrl_oe, output ack);
  modport walk (output walk_req, output cycle_busy, output grant_in,
                input grant_out, input ctrl_oe, input ack);
endinterface

/* verilog/lbus_yield.sv */
`timescale 1ns/100ps
module lbus_yield (
  input wire logic clk_in,
  input wire logic srst_in,
  yield_if.ctrl yif
);
  tw_pkg::yield_e state;

  // Ownership handshake; every output is a flop written with the state.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= tw_pkg::Y_IDLE;
      yif.grant_out <= 1'b0;
      yif.ctrl_oe <= 1'b0;
      yif.ack <= 1'b0;
    end else begin
      case (state)
        tw_pkg::Y_IDLE: begin
          if (yif.walk_req && !yif.grant_in) begin
            state <= tw_pkg::Y_OWN;
            yif.ack <= 1'b1;
            yif.ctrl_oe <= 1'b1;
          end
        end
        tw_pkg::Y_OWN: begin
          if (!yif.walk_req) begin
            state <= tw_pkg::Y_IDLE;
            yif.ack <= 1'b0;
            yif.ctrl_oe <= 1'b0;
          end else if (yif.grant_in) begin
            state <= tw_pkg::Y_PEND;
            yif.grant_out <= 1'b1;
          end
        end
        tw_pkg::Y_PEND: begin
          // The cycle in flight is allowed to end before anything floats.
          if (!yif.cycle_busy) begin
            state <= tw_pkg::Y_TRI;
            yif.ctrl_oe <= 1'b0;
          end
        end
        tw_pkg::Y_TRI: begin
          state <= tw_pkg::Y_OFF;
          yif.ack <= 1'b0;
          yif.grant_out <= 1'b0;
        end
        tw_pkg::Y_OFF: begin
          if (!yif.grant_in) begin
            state <= yif.walk_req ? tw_pkg::Y_OWN : tw_pkg::Y_IDLE;
            yif.ack <= yif.walk_req;
            yif.ctrl_oe <= yif.walk_req;
          end
        end
        default: begin
          state <= tw_pkg::Y_IDLE;
          yif.grant_out <= 1'b0;
          yif.ctrl_oe <= 1'b0;
          yif.ack <= 1'b0;
        end
      endcase
    end
  end

  sequence s_floated;
    yif.grant_out && !yif.ctrl_oe && yif.ack;
  endsequence

  a_grant_out_cause: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(yif.grant_out) |-> $past(yif.grant_in) && $past(yif.ack))
    else $error("grant out rose without grant in while owning");
  a_float_then_ack: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(yif.ctrl_oe) && yif.grant_out |-> s_floated ##1 !yif.ack)
    else $error("acknowledge not negated one cycle after floating");
  a_ack_needs_float: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(yif.ack) && $past(yif.grant_out) |-> $past(!yif.ctrl_oe))
    else $error("acknowledge negated while control lines driven");
endmodule // lbus_yield

/* verilog/table_walk_bus_yield.sv */
`timescale 1ns/100ps
// Summary of operation
// - Keep walking until grant in, then grant out.
// - On a yield, float shared lines before dropping grant acknowledge.
// - Miss walk waits for master retry after yield.
// - Resume if undisturbed, else restart whole walk.
// - Instruction walks resume or restart automatically.
// - No function code level adds two cycles.
// - Start on miss, instruction, or module call.
// - Upper bits index pages, lower bits offset.
// - Walk starts at root pointer physical address.
// - Protection and usage taken from table entries.
// - Page used-only update is read-modify-write.
// - Early startup disabled adds six cycles.
// - Index scaled four or eight by format.
module table_walk_bus_yield (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic miss_req_in,
  input wire logic instr_req_in,
  input wire logic modcall_req_in,
  input wire logic retry_in,
  input wire logic other_op_in,
  input wire logic write_access_in,
  input wire logic [31:0] logic_addr_in,
  input wire logic [2:0] fc_in,
  input wire logic [31:0] root_ptr_in,
  input wire logic root_long_in,
  input wire logic fc_lookup_in,
  input wire logic early_start_in,
  input wire logic [4:0] page_shift_in,
  input wire logic [2:0] addr_levels_in,
  input wire logic [3:0] idx_bits_in,
  input wire logic lbus_grant_in,
  input wire logic mem_done_in,
  input wire logic [31:0] mem_rdata_in,
  output logic lbus_grant_out,
  output logic lbus_grant_ack_out,
  output logic ctrl_oe_out,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic mem_rmw_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  output logic walk_done_out,
  output logic walk_fault_out,
  output logic write_prot_out,
  output logic [31:0] phys_addr_out,
  output logic busy_out
);
  // Local alias for the descriptor type field position; declared before its first use.
  localparam int DT_LSB = tw_pkg::DT_LSB;

  function automatic logic [31:0] page_mask(input logic [4:0] m);
    return (32'h1 << m) - 32'h1;
  endfunction

  function automatic logic [31:0] level_index(input logic [31:0] pa, input logic [2:0] n,
                                              input logic [2:0] k, input logic [3:0] b);
    logic [5:0] sh;
    sh = 6'(n - k - 3'h1) * 6'(b);
    return (pa >> sh) & ((32'h1 << b) - 32'h1);
  endfunction

  yield_if yif ();
  lbus_yield u_yield (.clk_in(clk_in), .srst_in(srst_in), .yif(yif));

  tw_pkg::walk_e state;
  logic [3:0] cnt;
  logic [2:0] lvl;
  logic [31:0] tbl_base;
  logic fmt_long;
  logic [31:0] desc;
  logic [31:0] addr;
  logic [2:0] fc;
  logic wr;
  logic src_instr;
  logic dirty;
  logic fc_lvl;
  logic [2:0] total;
  logic last_lvl;
  logic page_lvl;
  logic set_m;
  logic need_upd;
  logic may_issue;
  logic any_req;
  logic go_start;
  logic go_resume;
  logic [31:0] idx;
  logic [3:0] start_len;

  // Page address is the logical address above the in-page offset.
  assign fc_lvl = fc_lookup_in && (lvl == 3'h0);
  assign total = addr_levels_in + {2'h0, fc_lookup_in};
  assign last_lvl = (lvl == total - 3'h1);
  assign idx = fc_lvl ? {29'h0, fc} : level_index(addr >> page_shift_in, addr_levels_in,
                 lvl - {2'h0, fc_lookup_in}, idx_bits_in);
  assign page_lvl = (desc[DT_LSB+:2] == tw_pkg::DT_PAGE) || last_lvl;
  assign set_m = page_lvl && wr && !desc[tw_pkg::MOD_BIT];
  assign need_upd = !desc[tw_pkg::USED_BIT] || set_m;
  // A new cycle may start only while owning and with no yield pending.
  assign may_issue = yif.ack && !yif.grant_out;
  assign any_req = miss_req_in || instr_req_in || modcall_req_in;
  assign start_len = tw_pkg::BASE_START_CYC
                   + (early_start_in ? 4'h0 : tw_pkg::NO_EARLY_CYC)
                   + (fc_lookup_in ? 4'h0 : tw_pkg::ROOT_LIMIT_CYC);

  // Leaving the parked state: instruction walks go on their own, miss walks need a retry.
  always_comb begin
    go_resume = 1'b0;
    if (state == tw_pkg::W_PARK) begin
      if (src_instr) begin
        go_resume = yif.ack && !yif.grant_out;
      end else begin
        go_resume = retry_in && !yif.grant_out;
      end
    end
    go_start = ((state == tw_pkg::W_IDLE) && any_req)
             || (go_resume && (dirty || other_op_in));
  end

  assign yif.walk_req = (state != tw_pkg::W_IDLE) && ((state != tw_pkg::W_PARK) || src_instr);
  assign yif.cycle_busy = mem_req_out;
  assign yif.grant_in = lbus_grant_in;
  assign lbus_grant_out = yif.grant_out;
  assign lbus_grant_ack_out = yif.ack;
  assign ctrl_oe_out = yif.ctrl_oe;

  // Request capture; held through parking so a retry finds the same page.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      addr <= 32'h0;
      fc <= 3'h0;
      wr <= 1'b0;
      src_instr <= 1'b0;
    end else if ((state == tw_pkg::W_IDLE) && any_req) begin
      addr <= logic_addr_in;
      fc <= fc_in;
      wr <= write_access_in;
      src_instr <= instr_req_in;
    end
  end

  // Anything needing internal work while parked spoils the partial walk.
  always_ff @(posedge clk_in) begin
    if (srst_in || go_start) begin
      dirty <= 1'b0;
    end else if (state == tw_pkg::W_PARK) begin
      dirty <= dirty || other_op_in;
    end
  end

  // Walk sequencer with its bus cycles.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= tw_pkg::W_IDLE;
      cnt <= 4'h0;
      lvl <= 3'h0;
      tbl_base <= 32'h0;
      fmt_long <= 1'b0;
      desc <= 32'h0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_rmw_out <= 1'b0;
      mem_addr_out <= 32'h0;
      mem_wdata_out <= 32'h0;
      walk_done_out <= 1'b0;
      walk_fault_out <= 1'b0;
      write_prot_out <= 1'b0;
      phys_addr_out <= 32'h0;
    end else begin
      walk_done_out <= 1'b0;
      if (go_start) begin
        state <= tw_pkg::W_START;
        cnt <= start_len;
        lvl <= 3'h0;
        tbl_base <= root_ptr_in;
        fmt_long <= root_long_in;
        write_prot_out <= 1'b0;
      end else begin
        case (state)
          tw_pkg::W_IDLE: begin
          end
          tw_pkg::W_START: begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
              state <= tw_pkg::W_FETCH;
            end
          end
          tw_pkg::W_FETCH: begin
            if (mem_req_out) begin
              if (mem_done_in) begin
                mem_req_out <= 1'b0;
                desc <= mem_rdata_in;
                state <= tw_pkg::W_CHECK;
              end
            end else if (yif.grant_out) begin
              state <= tw_pkg::W_PARK;
            end else if (may_issue) begin
              mem_req_out <= 1'b1;
              mem_we_out <= 1'b0;
              mem_rmw_out <= 1'b0;
              mem_addr_out <= tbl_base + (idx << (fmt_long ? tw_pkg::LONG_SHIFT
                                                           : tw_pkg::SHORT_SHIFT));
            end
          end
          tw_pkg::W_CHECK: begin
            if (desc[DT_LSB+:2] == tw_pkg::DT_INVALID) begin
              walk_fault_out <= 1'b1;
              walk_done_out <= 1'b1;
              state <= tw_pkg::W_IDLE;
            end else if (need_upd) begin
              // Both bits at once go as a plain write; used-only on a page is atomic.
              mem_wdata_out <= desc | (32'h1 << tw_pkg::USED_BIT)
                                    | (set_m ? (32'h1 << tw_pkg::MOD_BIT) : 32'h0);
              mem_rmw_out <= page_lvl && !set_m;
              state <= tw_pkg::W_UPDATE;
            end else if (page_lvl) begin
              write_prot_out <= write_prot_out || desc[tw_pkg::WP_BIT];
              phys_addr_out <= (desc & ~page_mask(page_shift_in))
                             | (addr & page_mask(page_shift_in));
              walk_fault_out <= 1'b0;
              walk_done_out <= 1'b1;
              state <= tw_pkg::W_IDLE;
            end else begin
              write_prot_out <= write_prot_out || desc[tw_pkg::WP_BIT];
              tbl_base <= desc & tw_pkg::TBL_ADDR_MASK;
              fmt_long <= (desc[DT_LSB+:2] == tw_pkg::DT_LONG);
              lvl <= lvl + 3'h1;
              state <= tw_pkg::W_FETCH;
            end
          end
          tw_pkg::W_UPDATE: begin
            if (mem_req_out) begin
              if (mem_done_in) begin
                mem_req_out <= 1'b0;
                desc <= mem_wdata_out;
                state <= tw_pkg::W_CHECK;
              end
            end else if (yif.grant_out) begin
              state <= tw_pkg::W_PARK;
            end else if (may_issue) begin
              mem_req_out <= 1'b1;
              mem_we_out <= 1'b1;
            end
          end
          tw_pkg::W_PARK: begin
            if (go_resume) begin
              state <= tw_pkg::W_FETCH;
            end
          end
          default: begin
            state <= tw_pkg::W_IDLE;
          end
        endcase
      end
    end
  end

  // Busy flag is registered so the port comes straight from a flop.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state != tw_pkg::W_IDLE) || any_req;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_parked_miss;
    state == tw_pkg::W_PARK && !src_instr;
  endsequence

  a_miss_waits_retry: assert property (s_parked_miss and !retry_in |=>
    state == tw_pkg::W_PARK) else $error("miss walk left park without retry");
  a_resume_clean: assert property (s_parked_miss and retry_in && !yif.grant_out
    && !dirty && !other_op_in |=> state == tw_pkg::W_FETCH && lvl == $past(lvl))
    else $error("clean retry did not resume at same level");
  a_restart_dirty: assert property (s_parked_miss and retry_in && !yif.grant_out
    && dirty |=> state == tw_pkg::W_START && lvl == 3'h0)
    else $error("disturbed walk did not restart");
  a_instr_resume: assert property (state == tw_pkg::W_PARK && src_instr && yif.ack
    && !yif.grant_out |=> state inside {tw_pkg::W_FETCH, tw_pkg::W_START})
    else $error("instruction walk not resumed after regaining bus");
  a_start_fast: assert property (go_start && early_start_in && fc_lookup_in |=>
    state == tw_pkg::W_START ##1 state == tw_pkg::W_FETCH)
    else $error("fast startup length wrong");
  a_start_root_limit: assert property (go_start && early_start_in && !fc_lookup_in
    |=> (state == tw_pkg::W_START)[*3] ##1 state == tw_pkg::W_FETCH)
    else $error("root limit check not two extra cycles");
  a_start_no_early: assert property (go_start && !early_start_in && !fc_lookup_in
    |=> (state == tw_pkg::W_START)[*8] ##1 state == tw_pkg::W_START
    ##1 state == tw_pkg::W_FETCH) else $error("slow startup length wrong");
  a_long_scale: assert property ($rose(mem_req_out) && !mem_we_out && fmt_long
    && !fc_lvl |-> mem_addr_out == tbl_base + (idx << 3))
    else $error("long descriptor index not scaled by eight");
  a_no_new_cycle: assert property ($past(yif.grant_out) |-> !$rose(mem_req_out))
    else $error("bus cycle started while yielding");
  a_rmw_used_only: assert property ($rose(mem_req_out) && mem_rmw_out |->
    mem_we_out && mem_wdata_out[tw_pkg::USED_BIT] && page_lvl)
    else $error("read-modify-write outside page used-only update");
endmodule // table_walk_bus_yield

/* verif/tw_mem_model.sv */
`timescale 1ns/100ps
// Descriptor memory beyond the walk's bus; the bench sets the answer latency.
module tw_mem_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic rmw_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] lat_in,
  output logic done_out,
  output logic [31:0] rdata_out
);
  logic [31:0] words [logic [31:0]];
  logic [64:0] wlog [$];
  logic [3:0] cnt = 4'h0;
  initial done_out = 1'b0;
  initial rdata_out = 32'h0;
  // Data is valid only with done; between answers the lines toggle so a stale word is unusable.
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !done_out) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat_in) begin
        cnt <= 4'h0;
        done_out <= 1'b1;
        if (we_in) begin
          words[addr_in] = wdata_in;
          wlog.push_back({rmw_in, addr_in, wdata_in});
        end else begin
          rdata_out <= words.exists(addr_in) ? words[addr_in] : 32'h0;
        end
      end
    end
  end
endmodule // tw_mem_model

/* verif/table_walk_bus_yield_bench.sv */
`timescale 1ns/100ps
// Self-checking bench for the table walk and its logical bus yield.
module table_walk_bus_yield_bench;
  typedef struct {logic early; logic fcl; logic lng; logic [2:0] fc; logic [31:0] fa;
    int extra;} row_s;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic miss = 1'b0, instr = 1'b0, modc = 1'b0, retry = 1'b0, other = 1'b0;
  logic fcl = 1'b0, early = 1'b1, lng = 1'b0, grant = 1'b0;
  logic wr = 1'b0, wp;
  logic [2:0] fc = 3'h3;
  logic [31:0] laddr = 32'h00005234;
  logic [3:0] lat = 4'h0;
  logic mem_req_out, mem_we_out, mem_rmw_out, mem_done, grant_out, ack, oe, done, fault, busy;
  logic [31:0] mem_addr_out, mem_wdata_out, rdata, phys;
  logic oe_prev;
  int errors = 0, total_checks = 0, n, lt, base;
  logic [31:0] fa;
  row_s rows [4] = '{'{1'b1, 1'b1, 1'b0, 3'h3, 32'h0000100C, 0},
                     '{1'b1, 1'b0, 1'b0, 3'h3, 32'h00001014, 2},
                     '{1'b0, 1'b0, 1'b1, 3'h3, 32'h00001028, 8},
                     '{1'b0, 1'b1, 1'b1, 3'h3, 32'h00001018, 6}};
  table_walk_bus_yield dut (.clk_in(clk_in), .srst_in(srst_in), .miss_req_in(miss),
    .instr_req_in(instr), .modcall_req_in(modc), .retry_in(retry), .other_op_in(other),
    .write_access_in(wr), .logic_addr_in(laddr), .fc_in(fc), .root_ptr_in(32'h00001000),
    .root_long_in(lng), .fc_lookup_in(fcl), .early_start_in(early), .page_shift_in(5'h0C),
    .addr_levels_in(3'h1), .idx_bits_in(4'h4), .lbus_grant_in(grant), .mem_done_in(mem_done),
    .mem_rdata_in(rdata), .lbus_grant_out(grant_out), .lbus_grant_ack_out(ack),
    .ctrl_oe_out(oe), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .mem_rmw_out(mem_rmw_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .walk_done_out(done), .walk_fault_out(fault), .write_prot_out(wp), .phys_addr_out(phys),
    .busy_out(busy));
  tw_mem_model mem (.clk_in(clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .rmw_in(mem_rmw_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .lat_in(lat),
    .done_out(mem_done), .rdata_out(rdata));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  task test_done();
    $display("checks=%0d mismatches=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [64:0] got, input logic [64:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Samples land one step after the edge so that the edge's own updates are settled.
  task cyc();
    @(posedge clk_in);
    #1;
  endtask
  // Waits a bounded time for a chosen output; a hang ends the run as a mismatch.
  task wait_for(input int which, input logic val, output int cnt);
    logic [3:0] s;
    cnt = 0;
    s = {done, ack, grant_out, mem_req_out};
    while (s[which] !== val) begin
      oe_prev = oe;
      cyc();
      s = {done, ack, grant_out, mem_req_out};
      cnt++;
      if (cnt > 400) begin
        errors++;
        test_done();
      end
    end
  endtask
  // Counts cycles in which the unit runs a memory cycle.
  task quiet(input int len, output int hits);
    hits = 0;
    repeat (len) begin
      cyc();
      if (mem_req_out !== 1'b0) hits++;
    end
  endtask
  task start(input logic [2:0] kind);
    {modc, instr, miss} <= kind;
    cyc();
    {modc, instr, miss} <= 3'h0;
  endtask
  task run(input logic [2:0] kind);
    start(kind);
    wait_for(0, 1'b1, lt);
    fa = mem_addr_out;
    wait_for(3, 1'b1, n);
  endtask
  // Yields during the first fetch, so the walk parks before the next level's fetch,
  // then brings the walk back by retry or by itself.
  task yield_walk(input logic [2:0] kind, input logic op, input logic [31:0] exp_fa);
    lat <= 4'h6;
    start(kind);
    wait_for(0, 1'b1, n);
    grant <= 1'b1;
    wait_for(1, 1'b1, n);
    chk(n, 1);
    wait_for(2, 1'b0, n);
    chk({oe_prev, oe, grant_out, mem_req_out}, 4'h0);
    quiet(8, n);
    chk(n, 0);
    grant <= 1'b0;
    if (kind != 3'h2) begin
      quiet(8, n);
      chk({n, done}, 33'h0);
      other <= op;
      cyc();
      other <= 1'b0;
      retry <= 1'b1;
      cyc();
      retry <= 1'b0;
    end
    wait_for(0, 1'b1, n);
    chk(mem_addr_out, exp_fa);
    wait_for(3, 1'b1, n);
    chk(phys, 32'h00080234);
    lat <= 4'h0;
    $display("yield test kind %0h done", kind);
  endtask
  initial begin
    mem.words[32'h0000100C] = 32'h0000200A;
    mem.words[32'h00001018] = 32'h0000200A;
    mem.words[32'h0000101C] = 32'h0000200A;
    mem.words[32'h00001014] = 32'h00080009;
    mem.words[32'h00001028] = 32'h00080009;
    mem.words[32'h0000102C] = 32'h00080009;
    mem.words[32'h00002014] = 32'h00080009;
    repeat (2) cyc();
    srst_in <= 1'b0;
    chk({busy, ack, oe, grant_out, mem_req_out, done}, 6'h0);
    // Startup overhead is measured against the fastest configuration in the first row.
    for (int r = 0; r < 4; r++) begin
      early <= rows[r].early;
      fcl <= rows[r].fcl;
      lng <= rows[r].lng;
      fc <= rows[r].fc;
      run(3'h2);
      if (r == 0) base = lt;
      chk(fa, rows[r].fa);
      chk(lt, base + rows[r].extra);
      chk({wp, fault, phys}, {2'b0, 32'h00080234});
      $display("row %0d done", r);
    end
    early <= 1'b1;
    fcl <= 1'b1;
    lng <= 1'b0;
    mem.words[32'h0000100C] = 32'h00002002;
    mem.words[32'h00002014] = 32'h00080001;
    run(3'h1);
    chk(mem.wlog.size(), 2);
    chk(mem.wlog[0], {1'b0, 32'h0000100C, 32'h0000200A});
    chk(mem.wlog[1], {1'b1, 32'h00002014, 32'h00080009});
    // A write access sets the modified bit, which must go as one plain write.
    wr <= 1'b1;
    run(3'h1);
    wr <= 1'b0;
    chk(mem.wlog[2], {1'b0, 32'h00002014, 32'h00080019});
    $display("status update test done");
    mem.words[32'h0000100C] = 32'h00000000;
    run(3'h1);
    chk(fault, 1'b1);
    mem.words[32'h0000100C] = 32'h0000200E;
    $display("fault test done");
    // A protected pointer above the page must show up as write protection.
    run(3'h1);
    chk({wp, phys}, {1'b1, 32'h00080234});
    mem.words[32'h0000100C] = 32'h0000200A;
    $display("protection test done");
    yield_walk(3'h2, 1'b0, 32'h00002014);
    yield_walk(3'h1, 1'b0, 32'h00002014);
    yield_walk(3'h4, 1'b1, 32'h0000100C);
    start(3'h1);
    srst_in <= 1'b1;
    repeat (2) cyc();
    srst_in <= 1'b0;
    chk({busy, ack, oe, grant_out, mem_req_out}, 5'h0);
    $display("mid-run reset test done");
    test_done();
  end
endmodule // table_walk_bus_yield_bench
